// [lpddr_cmd_pkg.sv]
// Shared constants and types for the bank command legality link
package lpddr_cmd_pkg;
  localparam int BANKS = 4;
  localparam int BA_W = 2;
  localparam int ADDR_W = 14;
  localparam int AP_BIT = 10;
  localparam int CLK_PERIOD_NS = 8;
  // Timing figures in ns and their cycle counts (least times round up)
  localparam int MODE_REGISTER_DELAY_NS = 16;
  localparam int ROW_TO_COLUMN_DELAY_NS = 24;
  localparam int ROW_PRECHARGE_NS = 24;
  localparam int WRITE_RECOVERY_TIME_NS = 16;
  localparam int ROW_CYCLE_INTERVAL_NS = 80;
  localparam int BANK_TO_BANK_ACTIVATE_DELAY_NS = 16;
  localparam int SELF_REFRESH_EXIT_TIME_NS = 120;
  localparam int POWER_DOWN_EXIT_TIME_NS = 8;
  function automatic int cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : cyc
  localparam int T_MRD = cyc(MODE_REGISTER_DELAY_NS);
  localparam int T_RCD = cyc(ROW_TO_COLUMN_DELAY_NS);
  localparam int T_RP = cyc(ROW_PRECHARGE_NS);
  localparam int T_WR = cyc(WRITE_RECOVERY_TIME_NS);
  localparam int T_RC = cyc(ROW_CYCLE_INTERVAL_NS);
  localparam int T_RRD = cyc(BANK_TO_BANK_ACTIVATE_DELAY_NS);
  localparam int T_XSR = cyc(SELF_REFRESH_EXIT_TIME_NS);
  localparam int T_XP = cyc(POWER_DOWN_EXIT_TIME_NS);
  localparam int BURST_LEN = 4;
  localparam int READ_PAIRS = BURST_LEN / 2;
  localparam int CNT_W = 5;
  // Command pin codes {ras_n, cas_n, we_n} with select low
  localparam logic [2:0] PIN_NOP = 3'h7;
  localparam logic [2:0] PIN_ACT = 3'h3;
  localparam logic [2:0] PIN_RD = 3'h5;
  localparam logic [2:0] PIN_WR = 3'h4;
  localparam logic [2:0] PIN_PRE = 3'h2;
  localparam logic [2:0] PIN_BST = 3'h6;
  localparam logic [2:0] PIN_REF = 3'h1;
  localparam logic [2:0] PIN_MRS = 3'h0;
  typedef enum logic [3:0] {
    CMD_DESEL, CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE,
    CMD_BST, CMD_REF, CMD_MRS
  } cmd_e;
  typedef enum logic [2:0] {
    BK_IDLE, BK_ACTIVATING, BK_ACTIVE, BK_READ, BK_WRITE,
    BK_AP_ACCESS, BK_AP_PRECHARGE, BK_PRECHARGING
  } bank_e;
  typedef enum logic [1:0] {
    EXIT_NONE, EXIT_POWER_DOWN, EXIT_SELF_REFRESH
  } exit_e;
  function automatic cmd_e decode(input logic cs_n, input logic [2:0] p);
    cmd_e c;
    c = CMD_DESEL;
    if (!cs_n) begin
      case (p)
        PIN_NOP: c = CMD_NOP;
        PIN_ACT: c = CMD_ACT;
        PIN_RD: c = CMD_RD;
        PIN_WR: c = CMD_WR;
        PIN_PRE: c = CMD_PRE;
        PIN_BST: c = CMD_BST;
        PIN_REF: c = CMD_REF;
        default: c = CMD_MRS;
      endcase
    end
    return c;
  endfunction : decode
endpackage : lpddr_cmd_pkg

// [lpddr_cmd_if.sv]
// Command pin bundle between memory controller and memory device
`timescale 1ns/1ns
interface lpddr_cmd_if;
  logic cke;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [lpddr_cmd_pkg::BA_W-1:0] ba;
  logic [lpddr_cmd_pkg::ADDR_W-1:0] addr;
  logic [1:0] dm;
  modport ctrl (output cke, cs_n, ras_n, cas_n, we_n, ba, addr, dm);
  modport dev (input cke, cs_n, ras_n, cas_n, we_n, ba, addr, dm);
endinterface : lpddr_cmd_if

// [lpddr_bank_command_legality.sv]
// Device end: command decode, per-bank states and legality checking
//
// Functional notes
// - Mode register access lasts mode delay
// - Precharge all precharges every bank; banks activating or auto-closing are flagged and left unchanged
// - Controller sends mode set only idle
// - Burst terminate cuts latest read anywhere
// - Controller ends read before write
// - Decode commands from select and strobes
// - Check only when clock enable steady
// - Idle bank allows commands elsewhere
// - Busy bank allows row commands elsewhere
// - Read auto-close splits access, precharge
// - Write auto-close precharge after recovery
// - Auto-close access limits other banks
// - Refresh and mode set need idle
// - Controller masks trailing write data
// - Deselect and no-op register nothing
// - Mode set loads register from address
// - Activate opens row in chosen bank
// - Controller waits row-to-column delay
// - Controller closes row, waits cycle interval
// - Controller spaces activates across banks
// - Row stays open until closed
// - Read bursts, A10 selects auto close
// - Store write data only mask low
`timescale 1ns/1ns
module lpddr_bank_command_legality (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  // Command pins
  lpddr_cmd_if.dev bus,
  // Write data lane enables from the data path
  input wire logic [1:0] i_wr_beat,
  // Status
  output logic o_illegal,
  output logic o_all_idle,
  output logic [lpddr_cmd_pkg::ADDR_W-1:0] o_mode_reg,
  output logic [lpddr_cmd_pkg::ADDR_W-1:0] o_ext_mode_reg,
  output logic [1:0] o_byte_store,
  output logic [lpddr_cmd_pkg::BANKS*3-1:0] o_bank_state,
  output logic [lpddr_cmd_pkg::BANKS*lpddr_cmd_pkg::ADDR_W-1:0] o_open_row
);
  localparam int NB = lpddr_cmd_pkg::BANKS;
  localparam int AW = lpddr_cmd_pkg::ADDR_W;
  localparam int CW = lpddr_cmd_pkg::CNT_W;
  typedef logic [CW-1:0] cnt_t;

  // -------------------------------------------------------------
  // Pin synchronisers
  // -------------------------------------------------------------
  // Pins come from outside, so two stages before any decode
  logic [AW+10:0] meta_r, sync_r;
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= {bus.cke, bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n,
                 bus.ba, bus.addr, bus.dm, i_wr_beat};
      sync_r <= meta_r;
    end
  end
  logic cke, cs_n;
  logic [2:0] pins;
  logic [1:0] ba, dm, beat;
  logic [AW-1:0] addr;
  assign {cke, cs_n, pins, ba, addr, dm, beat} = sync_r;

  // -------------------------------------------------------------
  // State
  // -------------------------------------------------------------
  lpddr_cmd_pkg::bank_e st_r [NB], st_nxt [NB];
  cnt_t cnt_r [NB], cnt_nxt [NB];
  logic [AW-1:0] row_r [NB], row_nxt [NB];
  logic cke_prev_r, cke_prev_nxt;
  logic mrs_r, mrs_nxt;
  cnt_t mrs_cnt_r, mrs_cnt_nxt;
  lpddr_cmd_pkg::exit_e exit_r, exit_nxt;
  cnt_t exit_cnt_r, exit_cnt_nxt;
  logic [1:0] last_rd_bank_r, last_rd_bank_nxt;
  logic rd_live_r, rd_live_nxt;
  logic [AW-1:0] mr_r, mr_nxt, emr_r, emr_nxt;
  logic illegal_r, illegal_nxt;
  logic [1:0] store_r, store_nxt;

  function automatic logic busy_elsewhere(input lpddr_cmd_pkg::bank_e s,
                                          input lpddr_cmd_pkg::cmd_e c);
    // An auto-close access period blocks column commands elsewhere
    busy_elsewhere = (s == lpddr_cmd_pkg::BK_AP_ACCESS) &&
                     (c == lpddr_cmd_pkg::CMD_RD ||
                      c == lpddr_cmd_pkg::CMD_WR);
  endfunction : busy_elsewhere

  // -------------------------------------------------------------
  // Next state
  // -------------------------------------------------------------
  always_comb begin
    lpddr_cmd_pkg::cmd_e cmd;
    logic checking, all_idle, bad, ap;
    cmd = lpddr_cmd_pkg::decode(cs_n, pins);
    checking = cke_prev_r && cke && !mrs_r &&
               (exit_r == lpddr_cmd_pkg::EXIT_NONE);
    ap = addr[lpddr_cmd_pkg::AP_BIT];
    all_idle = 1'b1;
    for (int b = 0; b < NB; b++) begin
      if (st_r[b] != lpddr_cmd_pkg::BK_IDLE) all_idle = 1'b0;
    end
    bad = 1'b0;
    cke_prev_nxt = cke;
    mrs_nxt = mrs_r;
    mrs_cnt_nxt = mrs_cnt_r;
    exit_nxt = exit_r;
    exit_cnt_nxt = exit_cnt_r;
    last_rd_bank_nxt = last_rd_bank_r;
    rd_live_nxt = rd_live_r;
    mr_nxt = mr_r;
    emr_nxt = emr_r;
    store_nxt = beat & ~dm;
    for (int b = 0; b < NB; b++) begin
      st_nxt[b] = st_r[b];
      row_nxt[b] = row_r[b];
      cnt_nxt[b] = (cnt_r[b] != '0) ? cnt_r[b] - cnt_t'(1) : cnt_r[b];
    end
    // Timed bank transitions, ongoing work runs on unaffected
    for (int b = 0; b < NB; b++) begin
      if (cnt_r[b] <= cnt_t'(1)) begin
        case (st_r[b])
          lpddr_cmd_pkg::BK_ACTIVATING: st_nxt[b] = lpddr_cmd_pkg::BK_ACTIVE;
          lpddr_cmd_pkg::BK_READ,
          lpddr_cmd_pkg::BK_WRITE: st_nxt[b] = lpddr_cmd_pkg::BK_ACTIVE;
          lpddr_cmd_pkg::BK_AP_ACCESS: begin
            st_nxt[b] = lpddr_cmd_pkg::BK_AP_PRECHARGE;
            cnt_nxt[b] = cnt_t'(lpddr_cmd_pkg::T_RP);
          end
          lpddr_cmd_pkg::BK_AP_PRECHARGE,
          lpddr_cmd_pkg::BK_PRECHARGING: st_nxt[b] = lpddr_cmd_pkg::BK_IDLE;
          default: st_nxt[b] = st_r[b];
        endcase
      end
    end
    // Mode register access and exit windows
    if (mrs_r) begin
      mrs_cnt_nxt = mrs_cnt_r - cnt_t'(1);
      if (mrs_cnt_r <= cnt_t'(1)) mrs_nxt = 1'b0;
    end
    if (!cke_prev_r && cke) begin
      exit_nxt = lpddr_cmd_pkg::EXIT_POWER_DOWN;
      exit_cnt_nxt = cnt_t'(lpddr_cmd_pkg::T_XP);
    end else if (exit_r != lpddr_cmd_pkg::EXIT_NONE) begin
      exit_cnt_nxt = exit_cnt_r - cnt_t'(1);
      if (exit_cnt_r <= cnt_t'(1)) exit_nxt = lpddr_cmd_pkg::EXIT_NONE;
    end
    // Command acceptance; deselect and no-op register nothing
    if (checking) begin
      for (int b = 0; b < NB; b++) begin
        if (b != int'(ba) && busy_elsewhere(st_r[b], cmd)) bad = 1'b1;
      end
      case (cmd)
        lpddr_cmd_pkg::CMD_DESEL, lpddr_cmd_pkg::CMD_NOP: bad = bad;
        lpddr_cmd_pkg::CMD_MRS: begin
          if (!all_idle) bad = 1'b1;
          else begin
            mrs_nxt = 1'b1;
            mrs_cnt_nxt = cnt_t'(lpddr_cmd_pkg::T_MRD);
            if (ba[0]) emr_nxt = addr;
            else mr_nxt = addr;
          end
        end
        lpddr_cmd_pkg::CMD_REF: if (!all_idle) bad = 1'b1;
        lpddr_cmd_pkg::CMD_ACT: begin
          if (st_r[ba] != lpddr_cmd_pkg::BK_IDLE) bad = 1'b1;
          else if (!bad) begin
            st_nxt[ba] = lpddr_cmd_pkg::BK_ACTIVATING;
            cnt_nxt[ba] = cnt_t'(lpddr_cmd_pkg::T_RCD);
            row_nxt[ba] = addr;
          end
        end
        lpddr_cmd_pkg::CMD_RD, lpddr_cmd_pkg::CMD_WR: begin
          if (st_r[ba] != lpddr_cmd_pkg::BK_ACTIVE &&
              st_r[ba] != lpddr_cmd_pkg::BK_READ &&
              st_r[ba] != lpddr_cmd_pkg::BK_WRITE) bad = 1'b1;
          else if (!bad) begin
            if (cmd == lpddr_cmd_pkg::CMD_RD) begin
              last_rd_bank_nxt = ba;
              rd_live_nxt = !ap;
              st_nxt[ba] = ap ? lpddr_cmd_pkg::BK_AP_ACCESS
                              : lpddr_cmd_pkg::BK_READ;
              cnt_nxt[ba] = cnt_t'(lpddr_cmd_pkg::READ_PAIRS);
            end else begin
              st_nxt[ba] = ap ? lpddr_cmd_pkg::BK_AP_ACCESS
                              : lpddr_cmd_pkg::BK_WRITE;
              cnt_nxt[ba] = cnt_t'(lpddr_cmd_pkg::READ_PAIRS +
                                   lpddr_cmd_pkg::T_WR);
            end
          end
        end
        lpddr_cmd_pkg::CMD_PRE: begin
          for (int b = 0; b < NB; b++) begin
            if (ap || b == int'(ba)) begin
              if (st_r[b] == lpddr_cmd_pkg::BK_AP_ACCESS ||
                  st_r[b] == lpddr_cmd_pkg::BK_AP_PRECHARGE ||
                  st_r[b] == lpddr_cmd_pkg::BK_ACTIVATING) bad = 1'b1;
              else if (st_r[b] != lpddr_cmd_pkg::BK_IDLE) begin
                st_nxt[b] = lpddr_cmd_pkg::BK_PRECHARGING;
                cnt_nxt[b] = cnt_t'(lpddr_cmd_pkg::T_RP);
              end
            end
          end
        end
        lpddr_cmd_pkg::CMD_BST: begin
          if (!rd_live_r) bad = 1'b1;
          else begin
            rd_live_nxt = 1'b0;
            if (st_r[last_rd_bank_r] == lpddr_cmd_pkg::BK_READ) begin
              st_nxt[last_rd_bank_r] = lpddr_cmd_pkg::BK_ACTIVE;
              cnt_nxt[last_rd_bank_r] = '0;
            end
          end
        end
        default: bad = 1'b1;
      endcase
    end else if (cke && cke_prev_r && cmd != lpddr_cmd_pkg::CMD_DESEL &&
                 cmd != lpddr_cmd_pkg::CMD_NOP) begin
      bad = 1'b1;
    end
    if (st_r[last_rd_bank_r] != lpddr_cmd_pkg::BK_READ &&
        cmd != lpddr_cmd_pkg::CMD_RD) rd_live_nxt = 1'b0;
    illegal_nxt = bad;
  end

  // -------------------------------------------------------------
  // Registers
  // -------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      for (int b = 0; b < NB; b++) begin
        st_r[b] <= lpddr_cmd_pkg::BK_IDLE;
        cnt_r[b] <= '0;
        row_r[b] <= '0;
      end
      cke_prev_r <= 1'b0;
      mrs_r <= 1'b0;
      mrs_cnt_r <= '0;
      exit_r <= lpddr_cmd_pkg::EXIT_NONE;
      exit_cnt_r <= '0;
      last_rd_bank_r <= '0;
      rd_live_r <= 1'b0;
      mr_r <= '0;
      emr_r <= '0;
      illegal_r <= 1'b0;
      store_r <= '0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      row_r <= row_nxt;
      cke_prev_r <= cke_prev_nxt;
      mrs_r <= mrs_nxt;
      mrs_cnt_r <= mrs_cnt_nxt;
      exit_r <= exit_nxt;
      exit_cnt_r <= exit_cnt_nxt;
      last_rd_bank_r <= last_rd_bank_nxt;
      rd_live_r <= rd_live_nxt;
      mr_r <= mr_nxt;
      emr_r <= emr_nxt;
      illegal_r <= illegal_nxt;
      store_r <= store_nxt;
    end
  end

  // -------------------------------------------------------------
  // Registered outputs
  // -------------------------------------------------------------
  logic all_idle_r;
  logic [NB*3-1:0] st_flat_r;
  logic [NB*AW-1:0] row_flat_r;
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      all_idle_r <= 1'b1;
      st_flat_r <= '0;
      row_flat_r <= '0;
    end else begin
      all_idle_r <= !mrs_nxt;
      for (int b = 0; b < NB; b++) begin
        if (st_nxt[b] != lpddr_cmd_pkg::BK_IDLE) all_idle_r <= 1'b0;
        st_flat_r[b*3 +: 3] <= st_nxt[b];
        row_flat_r[b*AW +: AW] <= row_nxt[b];
      end
    end
  end
  assign o_illegal = illegal_r;
  assign o_all_idle = all_idle_r;
  assign o_mode_reg = mr_r;
  assign o_ext_mode_reg = emr_r;
  assign o_byte_store = store_r;
  assign o_bank_state = st_flat_r;
  assign o_open_row = row_flat_r;
endmodule : lpddr_bank_command_legality

// [lpddr_cmd_issuer.sv]
// Controller end: drives one user command at a time onto the pins
`timescale 1ns/1ns
module lpddr_cmd_issuer (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  // User request
  input wire logic i_req,
  input wire logic [3:0] i_cmd,
  input wire logic [1:0] i_ba,
  input wire logic [lpddr_cmd_pkg::ADDR_W-1:0] i_addr,
  input wire logic [1:0] i_dm,
  // User answer
  output logic o_ready,
  output logic o_issued,
  // Pins
  lpddr_cmd_if.ctrl bus
);
  // Wait held after each command, covers the largest spacing
  localparam int GAP = lpddr_cmd_pkg::T_RC;
  typedef logic [lpddr_cmd_pkg::CNT_W-1:0] cnt_t;
  logic [2:0] pins_r, pins_nxt;
  logic cs_n_r, cs_n_nxt, issued_r, issued_nxt;
  logic [1:0] ba_r, ba_nxt, dm_r, dm_nxt;
  logic [lpddr_cmd_pkg::ADDR_W-1:0] addr_r, addr_nxt;
  cnt_t wait_r, wait_nxt;

  always_comb begin
    lpddr_cmd_pkg::cmd_e c;
    c = lpddr_cmd_pkg::cmd_e'(i_cmd);
    cs_n_nxt = 1'b1;
    pins_nxt = lpddr_cmd_pkg::PIN_NOP;
    ba_nxt = ba_r;
    addr_nxt = addr_r;
    dm_nxt = i_dm;
    issued_nxt = 1'b0;
    wait_nxt = (wait_r != '0) ? wait_r - cnt_t'(1) : wait_r;
    // Fixed worst-case spacing keeps mode, row and activate delays
    if (i_req && wait_r == '0) begin
      issued_nxt = 1'b1;
      wait_nxt = cnt_t'(GAP);
      ba_nxt = i_ba;
      addr_nxt = i_addr;
      cs_n_nxt = 1'b0;
      case (c)
        lpddr_cmd_pkg::CMD_ACT: pins_nxt = lpddr_cmd_pkg::PIN_ACT;
        lpddr_cmd_pkg::CMD_RD: pins_nxt = lpddr_cmd_pkg::PIN_RD;
        lpddr_cmd_pkg::CMD_WR: pins_nxt = lpddr_cmd_pkg::PIN_WR;
        lpddr_cmd_pkg::CMD_PRE: pins_nxt = lpddr_cmd_pkg::PIN_PRE;
        lpddr_cmd_pkg::CMD_BST: pins_nxt = lpddr_cmd_pkg::PIN_BST;
        lpddr_cmd_pkg::CMD_REF: pins_nxt = lpddr_cmd_pkg::PIN_REF;
        lpddr_cmd_pkg::CMD_MRS: pins_nxt = lpddr_cmd_pkg::PIN_MRS;
        lpddr_cmd_pkg::CMD_NOP: pins_nxt = lpddr_cmd_pkg::PIN_NOP;
        default: cs_n_nxt = 1'b1;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cs_n_r <= 1'b1;
      pins_r <= lpddr_cmd_pkg::PIN_NOP;
      ba_r <= '0;
      addr_r <= '0;
      dm_r <= 2'h3;
      issued_r <= 1'b0;
      wait_r <= '0;
    end else begin
      cs_n_r <= cs_n_nxt;
      pins_r <= pins_nxt;
      ba_r <= ba_nxt;
      addr_r <= addr_nxt;
      dm_r <= dm_nxt;
      issued_r <= issued_nxt;
      wait_r <= wait_nxt;
    end
  end
  assign bus.cke = i_rst_b;
  assign bus.cs_n = cs_n_r;
  assign {bus.ras_n, bus.cas_n, bus.we_n} = pins_r;
  assign bus.ba = ba_r;
  assign bus.addr = addr_r;
  assign bus.dm = dm_r;
  assign o_ready = (wait_r == '0);
  assign o_issued = issued_r;
endmodule : lpddr_cmd_issuer

// [lpddr_cmd_properties.sv]
// Assertions on the command link pins and the device status
`timescale 1ns/1ns
module lpddr_cmd_properties (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  // Link pins
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [lpddr_cmd_pkg::BA_W-1:0] ba,
  // Device status
  input wire logic o_illegal,
  input wire logic o_all_idle,
  input wire logic [lpddr_cmd_pkg::BANKS*3-1:0] o_bank_state
);
  localparam int RCD_HI = lpddr_cmd_pkg::T_RCD + 1;
  localparam int RP_HI = lpddr_cmd_pkg::T_RP + 1;
  logic [2:0] pins;
  logic [2:0] b0;
  logic [4:0] sel_r;
  assign pins = {ras_n, cas_n, we_n};
  assign b0 = o_bank_state[2:0];
  // Recent selects, so a rejection can be tied to a real command
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sel_r <= 5'h0;
    end else begin
      sel_r <= {sel_r[3:0], !cs_n};
    end
  end
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);
  cmd_one_cycle_a: assert property (!cs_n |=> cs_n)
    else $error("select held low beyond one cycle");
  cmd_spacing_a: assert property ($fell(cs_n) |=> cs_n [*8])
    else $error("commands issued too close together");
  // No command can reach the decision before the pins settle
  cke_settle_a: assert property (
    $rose(cke) |-> (!o_illegal && o_all_idle) [*4])
    else $error("status moved before clock enable settled");
  act_opens_a: assert property (
    (!cs_n && pins == lpddr_cmd_pkg::PIN_ACT && ba == 2'h0
     && b0 == lpddr_cmd_pkg::BK_IDLE)
    |-> ##[1:4] b0 == lpddr_cmd_pkg::BK_ACTIVATING)
    else $error("activate did not open bank 0");
  activate_done_a: assert property (
    $rose(b0 == lpddr_cmd_pkg::BK_ACTIVATING)
    |-> ##[1:RCD_HI] b0 == lpddr_cmd_pkg::BK_ACTIVE)
    else $error("bank 0 activation overran");
  precharge_done_a: assert property (
    $rose(b0 == lpddr_cmd_pkg::BK_PRECHARGING)
    |-> ##[1:RP_HI] b0 == lpddr_cmd_pkg::BK_IDLE)
    else $error("bank 0 precharge overran");
  auto_close_done_a: assert property (
    $rose(b0 == lpddr_cmd_pkg::BK_AP_PRECHARGE)
    |-> ##[1:RP_HI] b0 == lpddr_cmd_pkg::BK_IDLE)
    else $error("bank 0 auto close overran");
  mode_access_a: assert property (
    (!cs_n && pins == lpddr_cmd_pkg::PIN_MRS && o_all_idle)
    |-> ##[1:4] !o_all_idle ##[1:4] o_all_idle)
    else $error("mode access timing wrong");
  deselect_hold_a: assert property (
    (cs_n && o_all_idle) [*6] |=> o_all_idle)
    else $error("idle lost while deselected");
  illegal_cause_a: assert property (o_illegal |-> sel_r != 5'h0)
    else $error("rejection without a command");
  illegal_pulse_a: assert property (o_illegal |=> !o_illegal)
    else $error("rejection flag held");
  stop_no_read_a: assert property (
    (!cs_n && pins == lpddr_cmd_pkg::PIN_BST) |-> ##[1:4] o_illegal)
    else $error("burst stop without read accepted");
  cover property (!cs_n && pins == lpddr_cmd_pkg::PIN_ACT);
  cover property (!cs_n && pins == lpddr_cmd_pkg::PIN_MRS);
  cover property (o_illegal);
endmodule : lpddr_cmd_properties

// [test_lpddr_bank_command_legality.sv]
// Bench joining the controller end and the device end
`timescale 1ns/1ns
module test_lpddr_bank_command_legality;
  localparam logic [2:0] SI = lpddr_cmd_pkg::BK_IDLE;
  localparam logic [2:0] SA = lpddr_cmd_pkg::BK_ACTIVE;
  logic i_ref_clk;
  logic i_rst_b;
  logic i_req;
  logic [3:0] i_cmd;
  logic [1:0] i_ba;
  logic [13:0] i_addr;
  logic [1:0] i_dm;
  logic [1:0] i_wr_beat;
  logic o_ready;
  logic o_issued;
  logic o_illegal;
  logic o_all_idle;
  logic [13:0] o_mode_reg;
  logic [13:0] o_ext_mode_reg;
  logic [1:0] o_byte_store;
  logic [11:0] o_bank_state;
  logic [55:0] o_open_row;
  logic ill_seen;
  logic [1:0] store_seen;
  int n_errors;
  int comparisons;
  lpddr_cmd_if bus_if ();
  lpddr_cmd_issuer u_lpddr_cmd_issuer (.i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b), .i_req(i_req), .i_cmd(i_cmd), .i_ba(i_ba),
    .i_addr(i_addr), .i_dm(i_dm), .o_ready(o_ready),
    .o_issued(o_issued), .bus(bus_if));
  lpddr_bank_command_legality u_lpddr_bank_command_legality (
    .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .bus(bus_if),
    .i_wr_beat(i_wr_beat), .o_illegal(o_illegal),
    .o_all_idle(o_all_idle), .o_mode_reg(o_mode_reg),
    .o_ext_mode_reg(o_ext_mode_reg), .o_byte_store(o_byte_store),
    .o_bank_state(o_bank_state), .o_open_row(o_open_row));
  lpddr_cmd_properties u_lpddr_cmd_properties (.i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b), .cke(bus_if.cke), .cs_n(bus_if.cs_n),
    .ras_n(bus_if.ras_n), .cas_n(bus_if.cas_n), .we_n(bus_if.we_n),
    .ba(bus_if.ba), .o_illegal(o_illegal), .o_all_idle(o_all_idle),
    .o_bank_state(o_bank_state));
  initial begin
    i_ref_clk = 1'b0;
    forever #4 i_ref_clk = ~i_ref_clk;
  end
  // Pulses last one cycle, so keep them until the next command
  always @(posedge i_ref_clk) begin
    if (o_illegal === 1'b1) ill_seen <= 1'b1;
    store_seen <= store_seen | o_byte_store;
  end
  task automatic summarize();
    if (n_errors == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : summarize
  task automatic chk(input string name, input logic [63:0] exp,
      input logic [63:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // One user request, then room for the spacing and state settling
  task automatic issue(input lpddr_cmd_pkg::cmd_e c, input logic [1:0] b,
      input logic [13:0] a, input logic [1:0] m);
    int k;
    k = 0;
    while (o_ready !== 1'b1 && k < 40) begin
      @(posedge i_ref_clk);
      #1;
      k++;
    end
    chk("ready", 1, k < 40);
    ill_seen = 1'b0;
    store_seen = 2'h0;
    i_req = 1'b1;
    i_cmd = c;
    i_ba = b;
    i_addr = a;
    i_dm = m;
    @(posedge i_ref_clk);
    #1;
    i_req = 1'b0;
    chk("issued", 1, o_issued);
    chk("busy", 0, o_ready);
    repeat (14) @(posedge i_ref_clk);
    #1;
  endtask : issue
  initial begin
    #50000;
    n_errors++;
    summarize();
  end
  initial begin
    i_rst_b = 1'b0;
    i_req = 1'b0;
    i_cmd = 4'h0;
    i_ba = 2'h0;
    i_addr = 14'h0000;
    i_dm = 2'h3;
    i_wr_beat = 2'h3;
    ill_seen = 1'b0;
    store_seen = 2'h0;
    n_errors = 0;
    comparisons = 0;
    repeat (16) @(posedge i_ref_clk);
    #1;
    i_rst_b = 1'b1;
    chk("all_idle", 1, o_all_idle);
    chk("bank_state", 0, o_bank_state);
    repeat (4) @(posedge i_ref_clk);
    #1;
    issue(lpddr_cmd_pkg::CMD_MRS, 2'h0, 14'h0032, 2'h3);
    chk("mode_reg", 14'h0032, o_mode_reg);
    chk("all_idle", 1, o_all_idle);
    issue(lpddr_cmd_pkg::CMD_MRS, 2'h1, 14'h0021, 2'h3);
    chk("ext_mode_reg", 14'h0021, o_ext_mode_reg);
    issue(lpddr_cmd_pkg::CMD_ACT, 2'h0, 14'h1234, 2'h3);
    issue(lpddr_cmd_pkg::CMD_ACT, 2'h2, 14'h0567, 2'h3);
    chk("bank_state", {SI, SA, SI, SA}, o_bank_state);
    chk("row0", 14'h1234, o_open_row[13:0]);
    chk("row2", 14'h0567, o_open_row[41:28]);
    issue(lpddr_cmd_pkg::CMD_ACT, 2'h0, 14'h0abc, 2'h3);
    chk("illegal", 1, ill_seen);
    chk("row0", 14'h1234, o_open_row[13:0]);
    issue(lpddr_cmd_pkg::CMD_RD, 2'h0, 14'h0008, 2'h3);
    chk("illegal", 0, ill_seen);
    chk("bank_state", {SI, SA, SI, SA}, o_bank_state);
    issue(lpddr_cmd_pkg::CMD_BST, 2'h0, 14'h0000, 2'h3);
    chk("illegal", 1, ill_seen);
    issue(lpddr_cmd_pkg::CMD_WR, 2'h2, 14'h0010, 2'h1);
    chk("illegal", 0, ill_seen);
    chk("byte_store", 2'h2, store_seen);
    // Let the new lane and mask levels pass the pin stages first
    i_wr_beat = 2'h1;
    i_dm = 2'h0;
    repeat (4) @(posedge i_ref_clk);
    #1;
    issue(lpddr_cmd_pkg::CMD_RD, 2'h0, 14'h0400, 2'h0);
    chk("byte_store", 2'h1, store_seen);
    chk("bank_state", {SI, SA, SI, SI}, o_bank_state);
    issue(lpddr_cmd_pkg::CMD_WR, 2'h2, 14'h0400, 2'h3);
    chk("bank_state", 0, o_bank_state);
    issue(lpddr_cmd_pkg::CMD_ACT, 2'h1, 14'h0111, 2'h3);
    issue(lpddr_cmd_pkg::CMD_ACT, 2'h3, 14'h0333, 2'h3);
    issue(lpddr_cmd_pkg::CMD_MRS, 2'h0, 14'h0000, 2'h3);
    chk("illegal", 1, ill_seen);
    chk("mode_reg", 14'h0032, o_mode_reg);
    issue(lpddr_cmd_pkg::CMD_PRE, 2'h1, 14'h0000, 2'h3);
    chk("bank_state", {SA, SI, SI, SI}, o_bank_state);
    issue(lpddr_cmd_pkg::CMD_ACT, 2'h1, 14'h0222, 2'h3);
    issue(lpddr_cmd_pkg::CMD_PRE, 2'h0, 14'h0400, 2'h3);
    chk("bank_state", 0, o_bank_state);
    repeat (20) @(posedge i_ref_clk);
    #1;
    chk("all_idle", 1, o_all_idle);
    issue(lpddr_cmd_pkg::CMD_ACT, 2'h3, 14'h0444, 2'h3);
    i_rst_b = 1'b0;
    repeat (2) @(posedge i_ref_clk);
    #1;
    i_rst_b = 1'b1;
    chk("bank_state", 0, o_bank_state);
    chk("illegal", 0, o_illegal);
    // A command right after release lands in the exit window
    issue(lpddr_cmd_pkg::CMD_ACT, 2'h3, 14'h0444, 2'h3);
    chk("illegal", 1, ill_seen);
    chk("bank_state", 0, o_bank_state);
    issue(lpddr_cmd_pkg::CMD_ACT, 2'h3, 14'h0444, 2'h3);
    chk("bank_state", {SA, SI, SI, SI}, o_bank_state);
    summarize();
  end
endmodule : test_lpddr_bank_command_legality
